// file: common/flc_pkg.sv
// constants, register map and pin bundle of the flash host controller
package flc_pkg;
   // ==========================================================
   // clock and pin timing
   localparam int CLK_MHZ = 100;
   localparam int RST_LOW_NS = 100;
   localparam int WAKE_NS = 150;
   localparam int WE_PULSE_NS = 60;
   localparam int READ_ACC_NS = 120;
   localparam int GAP_NS = 30;
   localparam int RST_LOW_CYC = (RST_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
   localparam int WE_PULSE_CYC = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_ACC_CYC = (READ_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int SYNC_CYC = 2;
   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_WDATA = 8'h08;
   localparam logic [7:0] OFS_RDATA = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_CFG = 8'h14;
   // control word: bits [1:0] choose the pin operation
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_READ = 2'h1;
   localparam logic [1:0] OP_RESET = 2'h2;
   // status: bit0 busy, bit1 done
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int CFG_SUPPLY = 0;
   // ==========================================================
   // command codes written as data
   localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
   localparam logic [15:0] CMD_READ_ID = 16'h0090;
   localparam logic [15:0] CMD_READ_QUERY = 16'h0098;
   localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
   localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
   localparam logic [15:0] CMD_ERASE_SETUP = 16'h0020;
   localparam logic [15:0] CMD_CONFIRM = 16'h00d0;
   localparam logic [15:0] CMD_WORD_WRITE = 16'h0040;
   localparam logic [15:0] CMD_WORD_WRITE_ALT = 16'h0010;
   localparam logic [15:0] CMD_LOCK_SETUP = 16'h0060;
   localparam logic [15:0] CMD_LOCK = 16'h0001;
   localparam logic [15:0] CMD_LOCK_DOWN = 16'h002f;
   localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
   localparam logic [15:0] STATUS_AFTER_RESET = 16'h0080;
   localparam int ADDR_W = 22;
   // ==========================================================
   // pin bundle toward the flash part
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic rst_n;
      logic [ADDR_W-1:0] addr;
      logic [15:0] dq_out;
      logic dq_oe;
   } flc_pins_t;
   typedef enum logic [6:0] {
      S_IDLE = 7'b0000001,
      S_WR_PULSE = 7'b0000010,
      S_WR_END = 7'b0000100,
      S_RD_ACC = 7'b0001000,
      S_GAP = 7'b0010000,
      S_RST_LOW = 7'b0100000,
      S_RST_WAKE = 7'b1000000
   } flc_state_t;
endpackage

// file: logic/flc_host.sv
// host controller that drives a parallel flash part from apb registers
`timescale 1ns/100ps
module flc_host
   import flc_pkg::*;
#(
   parameter int RST_CYC = RST_LOW_CYC,
   parameter int WAKE_CYCLES = WAKE_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cke,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] dq_in,
   output flc_pins_t pins,
   output logic supply_high
);
   // ==========================================================
   // apb decode
   logic [ADDR_W-1:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic done;
   logic [7:0] cnt;
   logic [15:0] dq_meta;
   logic [15:0] dq_sync;
   flc_state_t state;
   wire access = psel && penable && !pready;
   wire take = psel && penable && pready;
   wire busy = (state != S_IDLE);
   wire sel_ctrl = (paddr == OFS_CTRL);
   wire sel_addr = (paddr == OFS_ADDR);
   wire sel_wdata = (paddr == OFS_WDATA);
   wire sel_rdata = (paddr == OFS_RDATA);
   wire sel_status = (paddr == OFS_STATUS);
   wire sel_cfg = (paddr == OFS_CFG);
   wire mapped = sel_ctrl | sel_addr | sel_wdata | sel_rdata | sel_status | sel_cfg;
   // a new operation while one runs is refused, so pins never glitch mid cycle
   wire refuse = !mapped || (pwrite && sel_ctrl && busy);
   // ops run one at a time, so a two-write command pair reaches the part in order
   wire go = take && pwrite && sel_ctrl && !busy;
   wire [1:0] op = pwdata[1:0];
   wire [31:0] rd_mux = sel_addr ? {{(32 - ADDR_W){1'b0}}, addr_reg} :
                        sel_wdata ? {16'h0000, wdata_reg} :
                        sel_rdata ? {16'h0000, rdata_reg} :
                        sel_status ? {30'h0, done, busy} :
                        sel_cfg ? {31'h0, supply_high} : 32'h00000000;

   // one wait state on every access; answer comes from flops
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (cke) begin
         pready <= access;
         pslverr <= access && refuse;
         prdata <= (access && !pwrite) ? rd_mux : 32'h00000000;
      end
   end

   // software registers; program supply level is a plain config bit
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         addr_reg <= '0;
         wdata_reg <= 16'h0000;
         supply_high <= 1'b0;
      end else if (cke && take && pwrite) begin
         if (sel_addr) begin
            addr_reg <= pwdata[ADDR_W-1:0];
         end
         if (sel_wdata) begin
            wdata_reg <= pwdata[15:0];
         end
         if (sel_cfg) begin
            supply_high <= pwdata[CFG_SUPPLY];
         end
      end
   end

   // ==========================================================
   // data pins come from another timing domain: two flops first
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dq_meta <= 16'h0000;
         dq_sync <= 16'h0000;
      end else if (cke) begin
         dq_meta <= dq_in;
         dq_sync <= dq_meta;
      end
   end

   // ==========================================================
   // pin sequencer
   wire cnt_end = (cnt == 8'h00);
   wire [7:0] cnt_dec = cnt - 8'h01;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
         cnt <= 8'h00;
         done <= 1'b0;
         rdata_reg <= 16'h0000;
         pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1,
                    addr: '0, dq_out: 16'h0000, dq_oe: 1'b0};
      end else if (cke) begin
         unique case (state)
            S_IDLE: begin
               if (go) begin
                  done <= 1'b0;
                  pins.addr <= addr_reg;
                  unique case (op)
                     OP_WRITE: begin
                        // select and strobe fall together; oe stays high
                        pins.ce_n <= 1'b0;
                        pins.we_n <= 1'b0;
                        pins.dq_out <= wdata_reg;
                        pins.dq_oe <= 1'b1;
                        cnt <= 8'(WE_PULSE_CYC - 1);
                        state <= S_WR_PULSE;
                     end
                     OP_READ: begin
                        pins.ce_n <= 1'b0;
                        pins.oe_n <= 1'b0;
                        cnt <= 8'(READ_ACC_CYC + SYNC_CYC - 1);
                        state <= S_RD_ACC;
                     end
                     default: begin
                        pins.rst_n <= 1'b0;
                        cnt <= 8'(RST_CYC - 1);
                        state <= S_RST_LOW;
                     end
                  endcase
               end
            end
            S_WR_PULSE: begin
               if (cnt_end) begin
                  // strobe rises first so the part samples on it, select still low
                  pins.we_n <= 1'b1;
                  state <= S_WR_END;
               end else begin
                  cnt <= cnt_dec;
               end
            end
            S_WR_END: begin
               pins.ce_n <= 1'b1;
               pins.dq_oe <= 1'b0;
               cnt <= 8'(GAP_CYC - 1);
               state <= S_GAP;
            end
            S_RD_ACC: begin
               if (cnt_end) begin
                  // sync delay is folded into the access count
                  rdata_reg <= dq_sync;
                  pins.ce_n <= 1'b1;
                  pins.oe_n <= 1'b1;
                  cnt <= 8'(GAP_CYC - 1);
                  state <= S_GAP;
               end else begin
                  cnt <= cnt_dec;
               end
            end
            S_GAP: begin
               if (cnt_end) begin
                  done <= 1'b1;
                  state <= S_IDLE;
               end else begin
                  cnt <= cnt_dec;
               end
            end
            S_RST_LOW: begin
               if (cnt_end) begin
                  pins.rst_n <= 1'b1;
                  cnt <= 8'(WAKE_CYCLES - 1);
                  state <= S_RST_WAKE;
               end else begin
                  cnt <= cnt_dec;
               end
            end
            S_RST_WAKE: begin
               // software then reads status until done is set, so it knows the wake time has passed
               if (cnt_end) begin
                  done <= 1'b1;
                  state <= S_IDLE;
               end else begin
                  cnt <= cnt_dec;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // checks on the flash pins and the apb ready this block drives
   AST_WE_UNDER_CE: assert property (@(posedge clock) disable iff (!rst_n)
      !pins.we_n |-> !pins.ce_n)
      else $error("write strobe low without chip select");
   AST_NO_CONTENTION: assert property (@(posedge clock) disable iff (!rst_n)
      pins.dq_oe |-> pins.oe_n)
      else $error("host drives data while output enable is low");
   AST_WE_RISES_FIRST: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(pins.we_n) |-> !pins.ce_n ##1 pins.ce_n)
      else $error("select did not outlast the write strobe by one cycle");
   AST_RST_WIDTH: assert property (@(posedge clock) disable iff (!rst_n || !cke)
      $fell(pins.rst_n) |-> !pins.rst_n [*8] ##1 !pins.rst_n ##1 !pins.rst_n)
      else $error("reset pin released before 100 ns");
   AST_QUIET_IN_RESET: assert property (@(posedge clock) disable iff (!rst_n)
      !pins.rst_n |-> pins.ce_n && pins.we_n && pins.oe_n && !pins.dq_oe)
      else $error("bus activity while reset pin is low");
   AST_READ_GAP: assert property (@(posedge clock) disable iff (!rst_n || !cke)
      $rose(pins.oe_n) |-> pins.ce_n [*3])
      else $error("no high gap between reads");
   AST_WRITE_STABLE: assert property (@(posedge clock) disable iff (!rst_n)
      !pins.we_n && $past(!pins.we_n) |-> $stable(pins.dq_out) && $stable(pins.addr))
      else $error("address or data moved under the write strobe");
   AST_PULSE_WIDTH: assert property (@(posedge clock) disable iff (!rst_n || !cke)
      $fell(pins.we_n) |-> !pins.we_n [*6] ##1 pins.we_n)
      else $error("write strobe width is not six cycles");
   AST_READY_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
      pready |=> !pready)
      else $error("ready held for two cycles");
endmodule

// file: dv/flc_flash.sv
// behavioural flash part answering the host controller pins
`timescale 1ns/100ps
module flc_flash
   import flc_pkg::*;
#(
   parameter logic [15:0] MAKER_CODE = 16'h1234, // arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h5678, // arbitrary value
   parameter int OP_NS = 800
) (
   input wire flc_pins_t pins,
   input wire logic supply_high,
   output logic [15:0] dq
);
   // ==========================================
   // state of the part
   logic [15:0] mem [16];
   logic [7:0] lk = 8'hff, dn = 8'h00, sts = 8'h80, sl = 8'h80, e;
   logic [1:0] mode = 2'd0; // array, id, query, status
   logic [15:0] pend = 16'h0, wd, ok_k, ok_d, rv, last = 16'h0;
   logic [ADDR_W-1:0] wa, ok_a;
   logic busy = 1'b0;
   logic susp = 1'b0;
   int seq = 0;
   wire wr = !pins.ce_n && !pins.we_n && pins.rst_n;
   wire drv = !pins.ce_n && !pins.oe_n && pins.rst_n;
   initial foreach (mem[i]) mem[i] = 16'hffff;
   // reset pin aborts running work; an aborted word is left as it was
   always @(pins.rst_n) begin
      seq++;
      busy = 1'b0;
      susp = 1'b0;
      mode = 2'd0;
      sts = 8'h80;
      lk = 8'hff;
      dn = 8'h00;
      pend = 16'h0;
   end
   // work ends after a fixed time unless a reset cut it short
   task automatic fin(input int s);
      #OP_NS;
      // a parked operation only ends once it has been resumed
      wait (!susp);
      if (s == seq) begin
         busy = 1'b0;
         sts[7] = 1'b1;
         if (ok_k == CMD_ERASE_SETUP) foreach (mem[i]) mem[i] = 16'hffff;
         else mem[ok_a[3:0]] = mem[ok_a[3:0]] & ok_d;
      end
   endtask
   // ==========================================
   // command decoder, captured where select or strobe rises first
   always @(negedge wr) begin
      if (pins.rst_n) begin
         wa = pins.addr;
         wd = pins.dq_out;
         e = (pend == CMD_ERASE_SETUP) ? 8'h20 : 8'h10;
         if (pend != 16'h0) begin
            mode = 2'd3;
            if (pend == CMD_ERASE_SETUP && wd != CMD_CONFIRM) sts = sts | 8'h30;
            else if (!supply_high) sts = sts | 8'h08 | e;
            else if (pend == CMD_LOCK_SETUP) begin
               if (wd == CMD_CONFIRM) lk = 8'h00;
               else lk[wa[17:15]] = 1'b1;
               if (wd == CMD_LOCK_DOWN) dn[wa[17:15]] = 1'b1;
            end else if (lk[wa[17:15]]) sts = sts | 8'h02 | e;
            else begin
               busy = 1'b1;
               sts[7] = 1'b0;
               ok_k = pend;
               ok_a = wa;
               ok_d = wd;
               seq++;
               fork
                  fin(seq);
               join_none
            end
            pend = 16'h0;
         end else begin
            case (wd)
               CMD_READ_ARRAY: if (!busy || susp) mode = 2'd0;
               CMD_READ_ID: mode = 2'd1;
               CMD_READ_QUERY: mode = 2'd2;
               CMD_READ_STATUS: mode = 2'd3;
               CMD_CLEAR_STATUS: if (!susp) sts = sts & 8'hc5;
               // suspend parks the running work; resume is a lone confirm code
               CMD_SUSPEND: if (busy && !susp) begin
                  susp = 1'b1;
                  sts = sts | 8'h80 | ((ok_k == CMD_ERASE_SETUP) ? 8'h40 : 8'h04);
                  mode = 2'd3;
               end
               CMD_CONFIRM: if (susp) begin
                  susp = 1'b0;
                  sts = sts & 8'h3b;
                  mode = 2'd3;
               end
               CMD_ERASE_SETUP, CMD_WORD_WRITE, CMD_WORD_WRITE_ALT, CMD_LOCK_SETUP: begin
                  pend = wd;
                  mode = 2'd3;
               end
               default: ;
            endcase
         end
      end
   end
   // status frozen at the start of each read, so a poll must toggle select or output enable
   always @(negedge (pins.ce_n | pins.oe_n)) sl = sts;
   // read word by mode
   always @* begin
      case (mode)
         2'd0: rv = mem[pins.addr[3:0]];
         2'd1: rv = (pins.addr[1:0] == 2'd0) ? MAKER_CODE : (pins.addr[1:0] == 2'd1) ?
            DEVICE_CODE : {14'h0, dn[pins.addr[17:15]], lk[pins.addr[17:15]]};
         2'd2: rv = (pins.addr[7:0] == 8'h10) ? 16'h0051 : 16'h0000;
         default: rv = {8'h00, sl};
      endcase
   end
   // released pins show the inverse of the last word, never a held value
   always @(negedge drv) last = ~rv;
   assign dq = drv ? rv : last;
endmodule

// file: dv/flc_host_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/100ps
module flc_host_tb
   import flc_pkg::*;
;
   typedef struct packed {
      logic [15:0] cmd;
      logic [21:0] ra;
      logic [15:0] exp;
   } flc_row_t;
   localparam logic [15:0] MAKER = 16'h1234; // arbitrary value
   localparam logic [15:0] DEVICE = 16'h5678; // arbitrary value
   // mode command, read address, word expected back
   localparam flc_row_t ROWS [7] = '{'{CMD_READ_ID, 22'h0, MAKER},
      '{CMD_READ_ID, 22'h1, DEVICE}, '{CMD_READ_ID, 22'h8002, 16'h0001},
      '{CMD_READ_STATUS, 22'h123, 16'h0080}, '{CMD_READ_QUERY, 22'h10, 16'h0051},
      '{16'h0033, 22'h10, 16'h0051}, '{CMD_READ_ARRAY, 22'h3, 16'hffff}};
   logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic cke = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rq;
   logic pready, pslverr, supply_high, rerr;
   logic [15:0] dq_in;
   flc_pins_t pins;
   int err_count = 0, tests_run = 0, cycles = 0;
   always #5 clock = ~clock;
   flc_host u_dut(.clock(clock), .rst_n(rst_n), .cke(cke), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dq_in(dq_in), .pins(pins), .supply_high(supply_high));
   // long operation time so a suspend surely lands while the erase still runs
   flc_flash #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .OP_NS(3000)) u_flash(.pins(pins),
      .supply_high(supply_high), .dq(dq_in));
   // ==========================================
   // shared tasks
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask
   // one apb transfer; the request stands until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rq = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wait_done();
      rq = 32'h0;
      while (rq[ST_DONE] !== 1'b1) apb(1'b0, OFS_STATUS, 32'h0);
   endtask
   task automatic fl_op(input logic [1:0] op, input logic [21:0] a, input logic [15:0] d);
      apb(1'b1, OFS_ADDR, {10'h0, a});
      apb(1'b1, OFS_WDATA, {16'h0, d});
      apb(1'b1, OFS_CTRL, {30'h0, op});
      wait_done();
   endtask
   task automatic wc(input logic [21:0] a, input logic [15:0] d);
      fl_op(OP_WRITE, a, d);
   endtask
   task automatic rc(input logic [21:0] a, input logic [31:0] exp);
      fl_op(OP_READ, a, 16'h0);
      apb(1'b0, OFS_RDATA, 32'h0);
      chk(rq, exp);
   endtask
   // status reads until the part reports ready
   task automatic poll();
      rq = 32'h0;
      while (rq[7] !== 1'b1) begin
         fl_op(OP_READ, 22'h0, 16'h0);
         apb(1'b0, OFS_RDATA, 32'h0);
      end
      chk(rq, 32'h0080);
   endtask
   // hang guard, well above the length of the sequence
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         close_out();
      end
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (5) @(posedge clock);
      chk(32'({pins.ce_n, pins.oe_n, pins.we_n, pins.rst_n, pins.dq_oe, supply_high}), 32'h3c);
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      apb(1'b0, 8'h18, 32'h1);
      chk({rq[30:0], rerr}, 32'h1);
      apb(1'b0, OFS_CFG, 32'h0);
      chk(rq, 32'h0);
      apb(1'b1, OFS_CFG, 32'h1);
      chk(32'(supply_high), 32'h1);
      foreach (ROWS[i]) begin
         wc(22'h0, ROWS[i].cmd);
         rc(ROWS[i].ra, 32'(ROWS[i].exp));
      end
      wc(22'h0, CMD_ERASE_SETUP);
      wc(22'h0, CMD_READ_ARRAY);
      rc(22'h0, 32'h00b0);
      apb(1'b1, OFS_CFG, 32'h0);
      wc(22'h0, CMD_ERASE_SETUP);
      wc(22'h0, CMD_CONFIRM);
      rc(22'h0, 32'h00b8);
      wc(22'h0, CMD_CLEAR_STATUS);
      wc(22'h0, CMD_READ_STATUS);
      rc(22'h0, 32'h0080);
      apb(1'b1, OFS_CFG, 32'h1);
      wc(22'h5, CMD_WORD_WRITE);
      wc(22'h5, 16'h1234);
      rc(22'h0, 32'h0092);
      wc(22'h0, CMD_CLEAR_STATUS);
      wc(22'h0, CMD_LOCK_SETUP);
      wc(22'h0, CMD_CONFIRM);
      wc(22'h5, CMD_WORD_WRITE);
      wc(22'h5, 16'h1234);
      rc(22'h0, 32'h0000);
      poll();
      wc(22'h6, CMD_WORD_WRITE_ALT);
      wc(22'h6, 16'h00ff);
      poll();
      wc(22'h0, CMD_READ_ARRAY);
      rc(22'h5, 32'h1234);
      rc(22'h6, 32'h00ff);
      wc(22'h0, CMD_ERASE_SETUP);
      wc(22'h8, CMD_CONFIRM);
      wc(22'h0, CMD_READ_ARRAY);
      rc(22'h5, 32'h0000);
      // park the erase, make a bad pair and try a clear while parked
      wc(22'h0, CMD_SUSPEND);
      wc(22'h0, CMD_ERASE_SETUP);
      wc(22'h0, CMD_READ_ARRAY);
      wc(22'h0, CMD_CLEAR_STATUS);
      rc(22'h0, 32'h00f0);
      wc(22'h0, CMD_READ_ARRAY);
      rc(22'h5, 32'h1234);
      wc(22'h0, CMD_CONFIRM);
      wc(22'h0, CMD_CLEAR_STATUS);
      poll();
      wc(22'h0, CMD_READ_ARRAY);
      rc(22'h5, 32'hffff);
      wc(22'h8000, CMD_LOCK_SETUP);
      wc(22'h8000, CMD_LOCK_DOWN);
      wc(22'h0, CMD_READ_ID);
      rc(22'h8002, 32'h0003);
      wc(22'h7, CMD_WORD_WRITE);
      wc(22'h7, 16'h0000);
      apb(1'b1, OFS_CTRL, 32'(OP_RESET));
      apb(1'b1, OFS_CTRL, 32'(OP_RESET));
      chk(32'(rerr), 32'h1);
      wait_done();
      wc(22'h0, CMD_READ_STATUS);
      rc(22'h0, 32'h0080);
      wc(22'h0, CMD_READ_ARRAY);
      rc(22'h7, 32'hffff);
      wc(22'h0, CMD_READ_ID);
      rc(22'h8002, 32'h0001);
      // mid-run reset of the controller: pins idle, status and config cleared
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      chk(32'({pins.ce_n, pins.oe_n, pins.we_n, pins.rst_n, pins.dq_oe, supply_high}), 32'h3c);
      rst_n <= 1'b1;
      @(posedge clock);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rq, 32'h0);
      // frozen enable: the transfer waits and no register moves until cke returns
      cke <= 1'b0;
      fork
         apb(1'b1, OFS_CFG, 32'h1);
         begin
            repeat (4) @(posedge clock);
            chk(32'({pready, supply_high}), 32'h0);
            cke <= 1'b1;
         end
      join
      chk(32'(supply_high), 32'h1);
      close_out();
   end
endmodule
